// file: hw/pctc_port_c_pins.v
// Port C pins 28 to 25: function mux, timers, clock routing, DMA pins
//
// What this block does
// - Rate generator outputs reach clock bank and pins
// - Ten clock inputs forwarded to clock bank
// - Timer source: cascade, sysclk, sysclk/16, pin
// - Four timer input pins, one per timer
// - Timer input captured on rise, fall, both
// - Reference match pulses low or toggles output
// - Timer pairs cascade into one 32-bit counter
// - Gate pins gate or restart timer pairs
// - Transmit granted only when clear-to-send low
// - Ethernet mode reads clear-to-send as collision
// - Clock pin five feeds system timers via generator
// - Timer clock pin disables generator path
// - DMA done and request-ack exclusive on pin
// - Two independent DMA handshake sets provided
`timescale 1ns/1ps
`default_nettype none
`include "pctc_defines.vh"

module pctc_port_c_pins (
    input  wire        clk,            // System clock, 250 MHz
    input  wire        sys_rst,        // Synchronous reset, active high
    input  wire [11:0] pin_func_sel,   // 3-bit function per pin, pin 28 low
    input  wire [3:0]  gpio_out,       // GPIO output data, pins 28..25
    input  wire [3:0]  gpio_dir_out,   // GPIO direction, 1 drives
    output reg  [3:0]  gpio_in,        // Synchronised pin levels
    input  wire [3:0]  pin_in,         // Pad input levels
    output reg  [3:0]  pin_out,        // Pad output levels
    output reg  [3:0]  pin_oe_n,       // Pad enable, low drives
    input  wire [7:0]  rate_gen_out,   // Rate generator outputs 1..8
    input  wire [3:0]  rate_gen_to_bank, // Generators 4..7 enabled to bank
    output reg  [7:0]  bank_rate_gen,  // Generators seen by clock bank
    input  wire [9:0]  ext_clock_pins, // Clock pins of other port pins
    output reg  [9:0]  bank_ext_clock, // Clock inputs 1..10 for clock bank
    input  wire [7:0]  tmr_src_sel,    // 2 bits per timer
    input  wire [7:0]  tmr_edge_sel,   // 2 bits per timer
    input  wire [3:0]  tmr_toggle,     // 1 toggle, 0 low pulse
    input  wire [1:0]  tmr_cascade,    // Pair 1-2, pair 3-4
    input  wire [3:0]  tmr_gate_en,    // Gate pin controls timer
    input  wire [3:0]  tmr_restart,    // Gate edge restarts instead of gating
    input  wire [63:0] tmr_ref,        // 16-bit reference per timer
    input  wire        timer_gate_a,   // Gate pin for timers 1 and 2
    output reg  [3:0]  tmr_match,      // Reference match pulse
    input  wire        serial_ctrl_2_rts, // Transmitter request-to-send
    input  wire        serial_ctrl_2_eth, // Ethernet mode
    output reg         serial_ctrl_2_grant, // Request granted
    output reg         collision_in,   // Collision indication
    input  wire        sys_ext_clock_in5_sel,   // Clock pin five drives generator 1
    input  wire        sys_sys_timer_clock_in_sel,  // Timer clock pin drives system timers
    input  wire        rate_gen1_int,  // Generator 1 internal clock
    output reg         sys_timer_tick, // System timer count enable
    output reg         rate_gen1_clk,  // Generator 1 input clock
    input  wire [1:0]  dma_done_sel,   // Per set: 1 done, 0 request-ack
    input  wire [1:0]  dma_ack,        // DMA acknowledge sets 1, 2
    input  wire [1:0]  dma_done,       // DMA done sets 1, 2
    input  wire [1:0]  dma_req_ack,    // DMA request-ack sets 1, 2
    output reg  [1:0]  dma_ack_pin,    // Acknowledge pins
    output reg  [1:0]  dma_share_pin   // Shared done/request-ack pins
);

    // =================================================================
    // Pad synchronisers: three stages, change taken when 2 and 3 agree
    reg [3:0] s1_r, s2_r, s3_r, stable_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
            stable_r <= 4'h0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            stable_r <= (s2_r & s3_r) | (stable_r & (s2_r | s3_r));
        end
    end
    wire [3:0] pin_s = stable_r;

    wire [2:0] fn0 = pin_func_sel[2:0];
    wire [2:0] fn1 = pin_func_sel[5:3];
    wire [2:0] fn2 = pin_func_sel[8:6];
    wire [2:0] fn3 = pin_func_sel[11:9];

    // =================================================================
    // Divide by 16 enable for timer sources
    reg [3:0] div_r;
    always @(posedge clk) begin
        if (sys_rst) div_r <= 4'h0;
        else div_r <= div_r + 4'h1;
    end
    wire div16_en = (div_r == `PCTC_DIV_LAST);

    // Timer input per timer: 1 on pin 28, 4 on pin 25; 2, 3 elsewhere
    wire [3:0] tin_pin = {pin_s[3] & (fn3 == `PCTC_FN_TIMER_IN),
                          ext_clock_pins[8], ext_clock_pins[9],
                          pin_s[0] & (fn0 == `PCTC_FN_TIMER_IN)};
    wire       gate_b = pin_s[1] & (fn1 == `PCTC_FN_AUX);

    // =================================================================
    // Timers
    reg  [`PCTC_TMR_W-1:0] cnt_r [0:3];
    reg  [3:0] tin_d_r, gate_d_r, tout_r;
    wire [3:0] gate_lvl = {gate_b, gate_b, timer_gate_a, timer_gate_a};
    wire [3:0] hit;
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_tmr
            wire [1:0] src = tmr_src_sel[2*i+1:2*i];
            wire [1:0] edg = tmr_edge_sel[2*i+1:2*i];
            wire rise = tin_pin[i] & ~tin_d_r[i];
            wire fall = ~tin_pin[i] & tin_d_r[i];
            wire pin_tick = ((edg == `PCTC_EDGE_RISE) & rise) |
                            ((edg == `PCTC_EDGE_FALL) & fall) |
                            ((edg == `PCTC_EDGE_BOTH) & (rise | fall));
            wire casc = (i % 2 == 1) ? (tmr_cascade[i/2] & hit[(i/2)*2]) : 1'b0;
            wire tick = (src == `PCTC_SRC_SYSCLK) | ((src == `PCTC_SRC_DIV16) & div16_en) |
                        ((src == `PCTC_SRC_PIN) & pin_tick) | ((src == `PCTC_SRC_CASCADE) & casc);
            wire gated = tmr_gate_en[i] & ~tmr_restart[i] & ~gate_lvl[i];
            wire rst_ev = tmr_gate_en[i] & tmr_restart[i] & gate_lvl[i] & ~gate_d_r[i];
            assign hit[i] = tick & ~gated & (cnt_r[i] == tmr_ref[16*i+15:16*i]);
            always @(posedge clk) begin
                if (sys_rst) begin
                    cnt_r[i] <= 16'h0000;
                    tout_r[i] <= 1'b1;
                    tmr_match[i] <= 1'b0;
                end else begin
                    tmr_match[i] <= hit[i];
                    if (rst_ev | hit[i]) cnt_r[i] <= 16'h0000;
                    else if (tick & ~gated) cnt_r[i] <= cnt_r[i] + 16'h0001;
                    if (hit[i]) tout_r[i] <= tmr_toggle[i] ? ~tout_r[i] : 1'b0;
                    else if (~tmr_toggle[i]) tout_r[i] <= 1'b1;
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (sys_rst) begin
            tin_d_r <= 4'h0;
            gate_d_r <= 4'h0;
        end else begin
            tin_d_r <= tin_pin;
            gate_d_r <= gate_lvl;
        end
    end

    // =================================================================
    // Pad mux; each function other than GPIO has a fixed direction
    reg [3:0] po_nxt, oe_nxt;
    always @* begin
        po_nxt = gpio_out;
        oe_nxt = ~gpio_dir_out;
        case (fn0)
            `PCTC_FN_RATE_GEN:  begin po_nxt[0] = rate_gen_out[3]; oe_nxt[0] = 1'b0; end
            `PCTC_FN_TIMER_OUT: begin po_nxt[0] = tout_r[1]; oe_nxt[0] = 1'b0; end
            `PCTC_FN_GPIO:      ;
            default:            oe_nxt[0] = 1'b1;
        endcase
        case (fn1)
            `PCTC_FN_RATE_GEN:  begin po_nxt[1] = rate_gen_out[4]; oe_nxt[1] = 1'b0; end
            `PCTC_FN_GPIO:      ;
            default:            oe_nxt[1] = 1'b1;
        endcase
        case (fn2)
            `PCTC_FN_RATE_GEN:  begin po_nxt[2] = rate_gen_out[5]; oe_nxt[2] = 1'b0; end
            `PCTC_FN_TIMER_OUT: begin po_nxt[2] = tout_r[2]; oe_nxt[2] = 1'b0; end
            `PCTC_FN_GPIO:      ;
            default:            oe_nxt[2] = 1'b1;
        endcase
        case (fn3)
            `PCTC_FN_RATE_GEN:  begin po_nxt[3] = rate_gen_out[6]; oe_nxt[3] = 1'b0; end
            `PCTC_FN_AUX:       begin po_nxt[3] = dma_ack[1]; oe_nxt[3] = 1'b0; end
            `PCTC_FN_GPIO:      ;
            default:            oe_nxt[3] = 1'b1;
        endcase
    end

    // =================================================================
    // Registered outputs
    wire cts_low = (fn0 == `PCTC_FN_AUX) & ~pin_s[0];
    wire ext_clock_in5_on = (fn1 == `PCTC_FN_CLOCK_IN) & sys_ext_clock_in5_sel;
    wire sys_timer_clock_in_on = (fn2 == `PCTC_FN_AUX) & sys_sys_timer_clock_in_sel;
    reg  sys_timer_clock_in_d_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_out <= 4'h0;
            pin_oe_n <= 4'hF;
            gpio_in <= 4'h0;
            bank_rate_gen <= 8'h00;
            bank_ext_clock <= 10'h000;
            serial_ctrl_2_grant <= 1'b0;
            collision_in <= 1'b0;
            sys_timer_tick <= 1'b0;
            rate_gen1_clk <= 1'b0;
            sys_timer_clock_in_d_r <= 1'b0;
            dma_ack_pin <= 2'h0;
            dma_share_pin <= 2'h0;
        end else begin
            pin_out <= po_nxt;
            pin_oe_n <= oe_nxt;
            gpio_in <= pin_s;
            bank_rate_gen <= {rate_gen_out[7], rate_gen_out[6:3] & rate_gen_to_bank, rate_gen_out[2:0]};
            bank_ext_clock <= {ext_clock_pins[9:7],
                               pin_s[3] & (fn3 == `PCTC_FN_CLOCK_IN),
                               pin_s[2] & (fn2 == `PCTC_FN_CLOCK_IN),
                               pin_s[1] & (fn1 == `PCTC_FN_CLOCK_IN),
                               pin_s[0] & (fn0 == `PCTC_FN_CLOCK_IN),
                               ext_clock_pins[2:0]};
            // Granted only while transmitter asks and the far end answers low
            serial_ctrl_2_grant <= serial_ctrl_2_rts & cts_low & ~serial_ctrl_2_eth;
            collision_in <= serial_ctrl_2_eth & (fn0 == `PCTC_FN_AUX) & pin_s[0];
            rate_gen1_clk <= ext_clock_in5_on ? pin_s[1] : rate_gen1_int;
            sys_timer_clock_in_d_r <= pin_s[2];
            // Timer pin wins; generator path then blocked entirely
            sys_timer_tick <= sys_timer_clock_in_on ? (pin_s[2] & ~sys_timer_clock_in_d_r) : rate_gen_out[0];
            dma_ack_pin <= dma_ack;
            dma_share_pin <= (dma_done & dma_done_sel) | (dma_req_ack & ~dma_done_sel);
        end
    end

endmodule
`default_nettype wire

// file: hw/pctc_defines.vh
// Constants for the port C timer and clock pin function block
`ifndef PCTC_DEFINES_VH
`define PCTC_DEFINES_VH

// =====================================================================
// Pin function select codes, 3 bits per pin
`define PCTC_FN_GPIO      3'h0
`define PCTC_FN_RATE_GEN  3'h1
`define PCTC_FN_CLOCK_IN  3'h2
`define PCTC_FN_TIMER_IN  3'h3
`define PCTC_FN_TIMER_OUT 3'h4
`define PCTC_FN_AUX       3'h5

// =====================================================================
// Timer clock source select codes
`define PCTC_SRC_CASCADE  2'h0
`define PCTC_SRC_SYSCLK   2'h1
`define PCTC_SRC_DIV16    2'h2
`define PCTC_SRC_PIN      2'h3

// =====================================================================
// Capture edge select codes
`define PCTC_EDGE_RISE    2'h1
`define PCTC_EDGE_FALL    2'h2
`define PCTC_EDGE_BOTH    2'h3

// =====================================================================
// Counts and widths
`define PCTC_DIV_RATIO    16
`define PCTC_DIV_LAST     4'hF
`define PCTC_NUM_PINS     4
`define PCTC_NUM_TIMERS   4
`define PCTC_TMR_W        16
`define PCTC_FN_RESET     12'h000

`endif

// file: testbench/pctc_board.sv
// Board model: the pads of port C pins 28..25 and the parties behind them
`timescale 1ns/1ps
`default_nettype none
module pctc_board (
    input  wire logic [3:0] pin_out,  // Device pad levels
    input  wire logic [3:0] pin_oe_n, // Device drives when low
    input  wire logic [3:0] ext_lvl,  // Level the far side drives
    output var  logic [3:0] pin_in    // Resolved pad level
);
    // =====================================================================
    // Pad resolution
    // Far side (clear-to-send, gate, clocks) drives only while the device is off
    always_comb
        for (int b = 0; b < 4; b++)
            pin_in[b] = pin_oe_n[b] ? ext_lvl[b] : pin_out[b];
endmodule
`default_nettype wire

// file: testbench/pctc_port_c_pins_checker.sv
// Assertion checker for the port C pin function block
`timescale 1ns/1ps
`default_nettype none
module pctc_chk (
    input wire logic        clk, sys_rst, sys_ext_clock_in5_sel, rate_gen1_int, rate_gen1_clk, collision_in,
    input wire logic        serial_ctrl_2_rts, serial_ctrl_2_eth, serial_ctrl_2_grant,
    input wire logic [11:0] pin_func_sel,
    input wire logic [63:0] tmr_ref,
    input wire logic [7:0]  rate_gen_out, bank_rate_gen,
    input wire logic [3:0]  gpio_dir_out, pin_oe_n, rate_gen_to_bank, tmr_match,
    input wire logic [1:0]  dma_done_sel, dma_done, dma_req_ack, dma_share_pin
);
    // =====================================================================
    // Properties: registered outputs against last cycle's inputs, and the length of the timer 2 match pulse
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_reset_tristate: assert property ($past(sys_rst) |-> pin_oe_n == 4'hF && tmr_match == 4'h0)
        else $error("pads not released after reset");
    chk_bank_gate: assert property (1'b1 |=> bank_rate_gen[6:3] == $past(rate_gen_out[6:3] & rate_gen_to_bank))
        else $error("clock bank generator gating wrong");
    chk_grant_cause: assert property (serial_ctrl_2_grant |-> $past(serial_ctrl_2_rts) && !$past(serial_ctrl_2_eth))
        else $error("grant without request");
    chk_coll_eth: assert property (collision_in |-> $past(serial_ctrl_2_eth))
        else $error("collision outside Ethernet mode");
    chk_match_pulse: assert property (tmr_match[1] && tmr_ref[31:16] != 16'h0000 |=> !tmr_match[1])
        else $error("match longer than one cycle");
    chk_oe_dir: assert property (!pin_oe_n[0] |-> $past(pin_func_sel[2:0]) inside {3'h1, 3'h4} ||
        ($past(pin_func_sel[2:0]) == 3'h0 && $past(gpio_dir_out[0])))
        else $error("pin 28 driven by an input function");
    chk_gen1_int: assert property (!sys_ext_clock_in5_sel |=> rate_gen1_clk == $past(rate_gen1_int))
        else $error("generator 1 not on internal clock");
    chk_share_sel: assert property (1'b1 |=> dma_share_pin ==
        $past((dma_done_sel & dma_done) | (~dma_done_sel & dma_req_ack)))
        else $error("shared DMA pin wrong");
    cov_grant: cover property (serial_ctrl_2_grant);
    cov_match: cover property (tmr_match[1]);
    cov_collision: cover property (collision_in);
endmodule
bind pctc_port_c_pins pctc_chk i_pctc_chk (.*);
`default_nettype wire

// file: testbench/pctc_port_c_pins_tb.sv
// Self-checking bench for the port C pin function block
`timescale 1ns/1ps
`default_nettype none
module pctc_port_c_pins_tb;
    // =====================================================================
    // Signals and instances
    logic        clk, sys_rst, timer_gate_a, serial_ctrl_2_rts, serial_ctrl_2_eth, sys_ext_clock_in5_sel, sys_sys_timer_clock_in_sel;
    logic        rate_gen1_int, serial_ctrl_2_grant, collision_in, sys_timer_tick, rate_gen1_clk, prev;
    logic [63:0] tmr_ref;
    logic [11:0] pin_func_sel;
    logic [9:0]  ext_clock_pins, bank_ext_clock;
    logic [7:0]  rate_gen_out, bank_rate_gen, tmr_src_sel, tmr_edge_sel;
    logic [3:0]  gpio_out, gpio_dir_out, gpio_in, pin_in, pin_out, pin_oe_n, ext_lvl, rate_gen_to_bank;
    logic [3:0]  tmr_toggle, tmr_gate_en, tmr_restart, tmr_match;
    logic [1:0]  tmr_cascade, dma_done_sel, dma_ack, dma_done, dma_req_ack, dma_ack_pin, dma_share_pin;
    int          error_cnt = 0, cmp_count = 0, ga, gb, lo, ch;
    pctc_port_c_pins i_pctc_port_c_pins (.*);
    pctc_board i_pctc_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl), .pin_in(pin_in));
    // =====================================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rst;
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset first so a stale count never runs past a lowered reference
    task automatic gap(input logic [1:0] src, input logic [15:0] rv, output int n);
        tmr_src_sel[3:2] = src;
        tmr_ref[31:16] = rv;
        rst();
        for (int r = 0; r < 2; r++) begin
            n = 0;
            do begin
                tick(1);
                n++;
            end while (tmr_match[1] !== 1'b1 && n < 3000);
        end
    endtask
    // =====================================================================
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // All tests take well under 20000 cycles
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        {sys_rst, timer_gate_a, serial_ctrl_2_rts, serial_ctrl_2_eth, sys_ext_clock_in5_sel, sys_sys_timer_clock_in_sel} = '0;
        {pin_func_sel, tmr_ref, ext_clock_pins, rate_gen_out, tmr_src_sel, tmr_edge_sel, gpio_out} = '0;
        {gpio_dir_out, ext_lvl, rate_gen_to_bank, tmr_toggle, tmr_gate_en, tmr_restart, tmr_cascade} = '0;
        {dma_done_sel, dma_ack, dma_done, dma_req_ack} = '0;
        rate_gen1_int = 1'b1;
        rst();
        tick(1);
        check(pin_oe_n, 4'hF);
        gpio_dir_out = 4'hF;
        gpio_out = 4'hA;
        tick(2);
        check({pin_oe_n, pin_out}, 8'h0A);
        gpio_dir_out = 4'h0;
        ext_lvl = 4'h5;
        tick(7);
        check({pin_oe_n, gpio_in}, 8'hF5);
        $display("gpio test done");
        pin_func_sel = 12'h249;
        for (int i = 0; i < 2; i++) begin
            rate_gen_out = i ? 8'h5A : 8'hA5;
            rate_gen_to_bank = 4'h3 << (2 * i);
            tick(2);
            check({pin_oe_n, pin_out, bank_rate_gen[6:3]}, {4'h0, rate_gen_out[6:3], rate_gen_out[6:3] & rate_gen_to_bank});
        end
        pin_func_sel = 12'h492;
        ext_clock_pins = 10'h2B5;
        ext_lvl = 4'h9;
        tick(7);
        check({pin_oe_n, bank_ext_clock}, {4'hF, ext_clock_pins[9:7], ext_lvl, ext_clock_pins[2:0]});
        sys_ext_clock_in5_sel = 1'b1;
        for (int i = 0; i < 2; i++) begin
            ext_lvl[1] = i[0];
            tick(7);
            check(rate_gen1_clk, ext_lvl[1]);
        end
        sys_ext_clock_in5_sel = 1'b0;
        $display("clock test done");
        pin_func_sel = 12'h004;
        gap(2'h1, 16'd2, ga);
        gap(2'h1, 16'd5, gb);
        check(64'(gb - ga), 64'd3);
        for (int m = 0; m < 2; m++) begin
            tmr_toggle = m ? 4'h2 : 4'h0;
            gap(2'h1, 16'd5, gb);
            lo = 0;
            ch = 0;
            prev = pin_out[0];
            for (int k = 0; k < gb; k++) begin
                tick(1);
                lo += (pin_out[0] === 1'b0);
                ch += (pin_out[0] !== prev);
                prev = pin_out[0];
            end
            check(64'(m ? ch : lo), 64'd1);
        end
        gap(2'h2, 16'd2, lo);
        gap(2'h2, 16'd3, ch);
        check(64'(ch - lo), 64'd16);
        tmr_gate_en = 4'h2;
        timer_gate_a = 1'b0;
        gap(2'h1, 16'd2, lo);
        timer_gate_a = 1'b1;
        gap(2'h1, 16'd2, ch);
        check(64'({lo == 3000, ch == 3}), 64'd3);
        $display("timer test done");
        pin_func_sel = 12'h140;
        rate_gen_out = 8'hFF;
        ext_lvl[2] = 1'b0;
        tick(7);
        check(sys_timer_tick, 1'b1);
        sys_sys_timer_clock_in_sel = 1'b1;
        tick(2);
        check(sys_timer_tick, 1'b0);
        ext_lvl[2] = 1'b1;
        lo = 0;
        repeat (8) begin
            tick(1);
            lo += (sys_timer_tick === 1'b1);
        end
        check(64'(lo), 64'd1);
        sys_sys_timer_clock_in_sel = 1'b0;
        $display("timer clock test done");
        pin_func_sel = 12'h005;
        serial_ctrl_2_rts = 1'b1;
        for (int i = 0; i < 3; i++) begin
            serial_ctrl_2_eth = (i == 2);
            ext_lvl[0] = (i != 0);
            tick(7);
            check({pin_oe_n[0], serial_ctrl_2_grant, collision_in}, i == 0 ? 3'b110 : i == 2 ? 3'b101 : 3'b100);
        end
        pin_func_sel = 12'hA00;
        {dma_ack, dma_done, dma_req_ack} = 6'h26;
        for (int i = 0; i < 4; i++) begin
            dma_done_sel = i[1:0];
            tick(2);
            check({pin_oe_n[3], pin_out[3], dma_ack_pin, dma_share_pin},
                  {2'b01, dma_ack, 2'(8'h4E >> (2 * i))});
        end
        $display("serial and DMA test done");
        end_of_test();
    end
endmodule
`default_nettype wire
